/* design/mcl_pkg.sv */
// Shared constants, register layout and helpers for the codec serial link
package mcl_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int COLD_MIN_NS   = 1000;
  localparam int WARM_MIN_NS   = 1000;
  localparam int READY_NS      = 2000;
  // Least times round up to whole cycles
  localparam logic [7:0] COLD_CYC  = 8'((COLD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] WARM_CYC  = 8'((WARM_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] READY_CYC = 8'((READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] STRAP_CNT = 8'h02;

  // ****************************************************************
  // Frame layout
  // ****************************************************************
  localparam logic [7:0] LAST_POS   = 8'hFF;
  localparam int         SLOT_LINE1 = 5;
  localparam int         SLOT_LINE2 = 10;
  localparam logic [1:0] ID_PRIMARY = 2'h3;

  // ****************************************************************
  // Control space
  // ****************************************************************
  localparam logic [6:0]  REG_RESET_IDX = 7'h3C;
  localparam logic [6:0]  REG_PWR_IDX   = 7'h3E;
  localparam logic [6:0]  REG_LINK_IDX  = 7'h56;
  localparam logic [15:0] REG_DEFAULT   = 16'h0000;
  localparam int PWR_ADC1_BIT  = 10;
  localparam int PWR_DAC1_BIT  = 11;
  localparam int PWR_ADC2_BIT  = 12;
  localparam int PWR_DAC2_BIT  = 13;
  localparam int LINK_HALT_BIT = 12;

  // ****************************************************************
  // Bus register offsets (bytes)
  // ****************************************************************
  localparam logic [4:0] AV_STATUS = 5'h00;
  localparam logic [4:0] AV_DAC1   = 5'h04;
  localparam logic [4:0] AV_DAC2   = 5'h08;
  localparam logic [4:0] AV_ADC1   = 5'h0C;
  localparam logic [4:0] AV_ADC2   = 5'h10;
  localparam logic [4:0] AV_FRAMES = 5'h14;
  localparam logic       AV_WAIT_RST = 1'b1;

  // Position of the last bit of a slot within the frame
  function automatic logic [7:0] slot_last(input int n);
    return 8'(16 + 20 * n - 1);
  endfunction

  // Tag of slot n in the captured slot-0 bits 15..3
  function automatic logic tag_of(input logic [12:0] tags, input int n);
    return tags[12 - n];
  endfunction

endpackage

/* design/mcl_pins_if.sv */
// Synchronised link pins passed from the sampler to the codec core
`timescale 1ns/1ps
`default_nettype none
interface mcl_pins_if;
  logic       bclk_rise;
  logic       bclk_fall;
  logic       mclk_rise;
  logic       sync_s;
  logic       sdo_s;
  logic       rst_n_s;
  logic [1:0] id_s;
  modport smp  (output bclk_rise, bclk_fall, mclk_rise, sync_s, sdo_s, rst_n_s, id_s);
  modport core (input  bclk_rise, bclk_fall, mclk_rise, sync_s, sdo_s, rst_n_s, id_s);
endinterface
`default_nettype wire

/* design/mcl_link_sampler.sv */
// Two-stage synchronisers and edge finders for the link pins
`timescale 1ns/1ps
`default_nettype none
module mcl_link_sampler (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       mclk,
  input  wire logic       bclk_sense,
  input  wire logic       link_sync,
  input  wire logic       link_sdo,
  input  wire logic       link_rst_n,
  input  wire logic [1:0] id_strap,
  mcl_pins_if.smp         pins
);
  typedef struct packed {
    logic [6:0] s1;
    logic [6:0] s2;
    logic       bclk_prev;
    logic       mclk_prev;
  } mcl_smp_t;

  mcl_smp_t st_q;
  mcl_smp_t st_d;

  // First stage feeds only the second stage
  always_comb begin
    st_d           = st_q;
    st_d.s1        = {id_strap, mclk, link_rst_n, link_sdo, link_sync, bclk_sense};
    st_d.s2        = st_q.s1;
    st_d.bclk_prev = st_q.s2[0];
    st_d.mclk_prev = st_q.s2[4];
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Edges and levels from the second stage
  assign pins.bclk_rise = st_q.s2[0] & ~st_q.bclk_prev;
  assign pins.bclk_fall = ~st_q.s2[0] & st_q.bclk_prev;
  assign pins.mclk_rise = st_q.s2[4] & ~st_q.mclk_prev;
  assign pins.sync_s    = st_q.s2[1];
  assign pins.sdo_s     = st_q.s2[2];
  assign pins.rst_n_s   = st_q.s2[3];
  assign pins.id_s      = st_q.s2[6:5];
endmodule
`default_nettype wire

/* design/mcl_codec_link.sv */
// Codec end of the five-wire serial link with control space and bus slave
//
// Register access over Avalon-MM and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module mcl_codec_link #(
  parameter int unsigned REG_WORDS = 64
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        mclk,
  input  wire logic        bclk_sense,
  output logic             bclk_drive,
  output logic             bclk_oe,
  input  wire logic        link_sync,
  input  wire logic        link_sdo,
  output logic             link_sdi,
  input  wire logic        link_rst_n,
  input  wire logic [1:0]  id_strap,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);
  import mcl_pkg::*;

  typedef struct packed {
    logic                       strap_done;
    logic                       primary;
    logic [7:0]                 cold_cnt;
    logic [7:0]                 warm_cnt;
    logic [7:0]                 rdy_cnt;
    logic                       bclk;
    logic                       sdi;
    logic                       in_frame;
    logic                       sync_prev;
    logic [7:0]                 pos;
    logic [19:0]                sr;
    logic [12:0]                tags;
    logic                       cmd_rd;
    logic [6:0]                 cmd_idx;
    logic [REG_WORDS-1:0][15:0] regs;
    logic                       rsp_pend;
    logic [6:0]                 rsp_idx;
    logic [15:0]                rsp_data;
    logic [1:0][15:0]           dac;
    logic [1:0]                 dac_full;
    logic [1:0][15:0]           adc;
    logic [1:0]                 adc_pend;
    logic [255:0]               tx_sh;
    logic [15:0]                frames;
    logic                       av_wait;
    logic [31:0]                av_rdata;
  } mcl_state_t;

  mcl_state_t   st_q;
  mcl_state_t   st_d;
  mcl_pins_if   pins ();
  logic         ready;
  logic         halt;
  logic [1:0]   pd_dac;
  logic [1:0]   pd_adc;
  logic [1:0]   req_n;
  logic         t1;
  logic         t2;
  logic         t5;
  logic         t10;
  logic [15:0]  s0;
  logic [19:0]  s1;
  logic [19:0]  s2;
  logic [19:0]  s5;
  logic [19:0]  s10;
  logic [255:0] frame;
  logic [19:0]  sr_n;
  logic [1:0]   adc_wr;
  logic         edge_seen;
  logic         frame_start;
  logic         cold_hit;
  logic         warm_hit;
  logic         ev_write;
  logic         ev_read;
  logic         ev_regrst;

  mcl_link_sampler u_sampler (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .mclk       (mclk),
    .bclk_sense (bclk_sense),
    .link_sync  (link_sync),
    .link_sdo   (link_sdo),
    .link_rst_n (link_rst_n),
    .id_strap   (id_strap),
    .pins       (pins)
  );

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    st_d        = st_q;
    adc_wr      = 2'h0;
    ev_write    = 1'b0;
    ev_read     = 1'b0;
    ev_regrst   = 1'b0;
    sr_n        = {st_q.sr[18:0], pins.sdo_s};
    ready       = (st_q.rdy_cnt == READY_CYC);
    halt        = st_q.regs[REG_LINK_IDX[6:1]][LINK_HALT_BIT];
    pd_dac      = {st_q.regs[REG_PWR_IDX[6:1]][PWR_DAC2_BIT],
                   st_q.regs[REG_PWR_IDX[6:1]][PWR_DAC1_BIT]};
    pd_adc      = {st_q.regs[REG_PWR_IDX[6:1]][PWR_ADC2_BIT],
                   st_q.regs[REG_PWR_IDX[6:1]][PWR_ADC1_BIT]};
    edge_seen   = pins.bclk_rise | pins.bclk_fall;
    // sync rise seen on a falling edge
    frame_start = pins.bclk_fall & pins.sync_s & ~st_q.sync_prev;
    cold_hit    = ~pins.rst_n_s & (st_q.cold_cnt >= COLD_CYC);
    warm_hit    = pins.sync_s & (st_q.warm_cnt >= WARM_CYC);

    // request decision; power-down keeps it active; halt forces high
    req_n[0] = halt | ~(pd_dac[0] | ~st_q.dac_full[0]);
    req_n[1] = halt | ~(pd_dac[1] | ~st_q.dac_full[1]);
    // ready bit and tags of the incoming frame
    t1  = ready;
    t2  = ready & st_q.rsp_pend;
    t5  = ready & st_q.adc_pend[0] & ~pd_adc[0] & ~halt;
    t10 = ready & st_q.adc_pend[1] & ~pd_adc[1] & ~halt;
    // tag for slot n at bit 15 minus n
    s0  = {ready, t1, t2, 2'h0, t5, 4'h0, t10, 5'h00};
    s1  = t1 ? {1'b0, st_q.rsp_pend ? st_q.rsp_idx : 7'h00, 2'h0, req_n[0], 4'h0,
                req_n[1], 4'h0} : 20'h00000;
    s2  = t2 ? {st_q.rsp_data, 4'h0} : 20'h00000;
    s5  = t5 ? {st_q.adc[0], 4'h0} : 20'h00000;
    s10 = t10 ? {st_q.adc[1], 4'h0} : 20'h00000;
    // 16 + 12 x 20 bits fill the frame
    frame = {s0, s1, s2, 40'h0, s5, 80'h0, s10, 40'h0};

    // Strap caught shortly after reset release, once rst sync is settled
    if (!st_q.strap_done && st_q.rdy_cnt == STRAP_CNT) begin
      st_d.primary    = (pins.id_s == ID_PRIMARY);
      st_d.strap_done = 1'b1;
    end
    // ready after settling time, held off while reset pin is low
    if (!pins.rst_n_s) begin
      st_d.rdy_cnt = 8'h00;
    end else if (st_q.rdy_cnt != READY_CYC) begin
      st_d.rdy_cnt = st_q.rdy_cnt + 8'h01;
    end
    // toggle on each master clock rise; stopped during reset pin low
    if (!st_q.primary || !pins.rst_n_s) begin
      st_d.bclk = 1'b0;
    end else if (pins.mclk_rise) begin
      st_d.bclk = ~st_q.bclk;
    end
    // time reset pin low with no bit clock
    st_d.cold_cnt = (!pins.rst_n_s && !edge_seen && st_q.cold_cnt != 8'hFF) ?
                    st_q.cold_cnt + 8'h01 : ((!pins.rst_n_s && !edge_seen) ? 8'hFF : 8'h00);
    // time sync high with no bit clock
    st_d.warm_cnt = (pins.sync_s && !edge_seen && st_q.warm_cnt != 8'hFF) ?
                    st_q.warm_cnt + 8'h01 : ((pins.sync_s && !edge_seen) ? 8'hFF : 8'h00);

    // Bus slave: one wait cycle, then a single acknowledge
    if ((avs_read || avs_write) && st_q.av_wait) begin
      st_d.av_wait  = 1'b0;
      st_d.av_rdata = 32'h00000000;
      if (avs_read) begin
        case (avs_address)
          AV_STATUS: st_d.av_rdata = {25'h0, st_q.primary, st_q.adc_pend, st_q.dac_full,
                                      st_q.in_frame, ready};
          AV_DAC1: begin
            st_d.av_rdata    = {16'h0000, st_q.dac[0]};
            st_d.dac_full[0] = 1'b0;
          end
          AV_DAC2: begin
            st_d.av_rdata    = {16'h0000, st_q.dac[1]};
            st_d.dac_full[1] = 1'b0;
          end
          AV_ADC1:   st_d.av_rdata = {16'h0000, st_q.adc[0]};
          AV_ADC2:   st_d.av_rdata = {16'h0000, st_q.adc[1]};
          AV_FRAMES: st_d.av_rdata = {16'h0000, st_q.frames};
          default:   st_d.av_rdata = 32'h00000000;
        endcase
      end else begin
        case (avs_address)
          AV_ADC1: begin
            st_d.adc[0] = avs_writedata[15:0];
            adc_wr[0]   = 1'b1;
          end
          AV_ADC2: begin
            st_d.adc[1] = avs_writedata[15:0];
            adc_wr[1]   = 1'b1;
          end
          default: st_d.av_wait = 1'b0;
        endcase
      end
    end else begin
      st_d.av_wait = AV_WAIT_RST;
    end

    // outgoing data sampled on bit clock fall
    if (pins.bclk_fall) begin
      st_d.sync_prev = pins.sync_s;
      if (st_q.in_frame) begin
        st_d.sr = sr_n;
        // frame-valid bit and twelve slot tags
        if (st_q.pos == slot_last(0)) begin
          st_d.tags = sr_n[15:3];
        end
        if (st_q.pos == slot_last(1)) begin
          st_d.cmd_rd  = sr_n[19];
          st_d.cmd_idx = sr_n[18:12];
        end
        if (st_q.pos == slot_last(2) && st_q.tags[12] && tag_of(st_q.tags, 1)) begin
          ev_read   = st_q.cmd_rd;
          ev_write  = ~st_q.cmd_rd & ~st_q.cmd_idx[0] & tag_of(st_q.tags, 2);
          ev_regrst = ~st_q.cmd_rd & (st_q.cmd_idx == REG_RESET_IDX);
          if (ev_read) begin
            st_d.rsp_pend = 1'b1;
            st_d.rsp_idx  = st_q.cmd_idx;
            st_d.rsp_data = st_q.cmd_idx[0] ? 16'h0000 : st_q.regs[st_q.cmd_idx[6:1]];
          end
          // register reset restores the control space only
          if (ev_regrst) begin
            for (int i = 0; i < int'(REG_WORDS); i++) begin
              st_d.regs[i] = REG_DEFAULT;
            end
          // write data from slot 2 bits 19:4
          end else if (ev_write) begin
            st_d.regs[st_q.cmd_idx[6:1]] = sr_n[19:4];
          end
        end
        // Line sample capture when tagged and powered
        if (st_q.pos == slot_last(SLOT_LINE1) && tag_of(st_q.tags, SLOT_LINE1) && !pd_dac[0]) begin
          st_d.dac[0]      = sr_n[19:4];
          st_d.dac_full[0] = 1'b1;
        end
        if (st_q.pos == slot_last(SLOT_LINE2) && tag_of(st_q.tags, SLOT_LINE2) && !pd_dac[1]) begin
          st_d.dac[1]      = sr_n[19:4];
          st_d.dac_full[1] = 1'b1;
        end
        st_d.in_frame = (st_q.pos != LAST_POS);
        st_d.pos      = st_q.pos + 8'h01;
      end
      // load the incoming frame and retire what it carries
      if (frame_start) begin
        st_d.in_frame = 1'b1;
        st_d.pos      = 8'h00;
        st_d.tx_sh    = frame;
        st_d.frames   = st_q.frames + 16'h0001;
        if (t2) begin
          st_d.rsp_pend = 1'b0;
        end
        st_d.adc_pend = st_q.adc_pend & ~{t10, t5};
      end
    end
    // Bus writes win over retirement in the same cycle
    st_d.adc_pend = st_d.adc_pend | adc_wr;

    // incoming data changes on bit clock rise
    if (pins.bclk_rise) begin
      st_d.sdi   = st_q.in_frame & st_q.tx_sh[255];
      st_d.tx_sh = {st_q.tx_sh[254:0], 1'b0};
    end

    // warm reset restarts framing, control space untouched
    if (warm_hit) begin
      st_d.in_frame  = 1'b0;
      st_d.pos       = 8'h00;
      st_d.tx_sh     = '0;
      st_d.sdi       = 1'b0;
      st_d.rdy_cnt   = 8'h00;
      st_d.rsp_pend  = 1'b0;
      st_d.sync_prev = 1'b1;
    end
    // cold reset returns everything but the cold timer to defaults
    if (cold_hit) begin
      st_d          = '0;
      st_d.av_wait  = AV_WAIT_RST;
      st_d.cold_cnt = st_q.cold_cnt;
    end
  end

  // control space only changes by command, cold reset or sys_rst, so a halted link keeps it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q         <= '0;
      st_q.av_wait <= AV_WAIT_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // secondary never drives the bit clock
  assign bclk_drive      = st_q.bclk;
  assign bclk_oe         = st_q.primary;
  assign link_sdi        = st_q.sdi;
  assign avs_readdata    = st_q.av_rdata;
  assign avs_waitrequest = st_q.av_wait;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_bclk_half: assert property (st_q.primary && pins.rst_n_s && pins.mclk_rise && !cold_hit
    |=> st_q.bclk != $past(st_q.bclk)) else $error("bit clock did not toggle");
  a_sdi_rise: assert property ($changed(st_q.sdi)
    |-> $past(pins.bclk_rise) || $past(warm_hit) || $past(cold_hit))
    else $error("incoming data changed off a rising edge");
  a_cold_clear: assert property (cold_hit |=> st_q.regs == '0 && st_q.rdy_cnt == 8'h00)
    else $error("cold reset left state behind");
  a_warm_keep: assert property (warm_hit && !cold_hit
    |=> st_q.regs == $past(st_q.regs) && !st_q.in_frame) else $error("warm reset lost registers");
  a_reg_reset: assert property (ev_regrst && !cold_hit |=> st_q.regs == '0)
    else $error("register reset incomplete");
  a_odd_read: assert property (ev_read && st_q.cmd_idx[0] && !cold_hit && !warm_hit
    |=> st_q.rsp_pend && st_q.rsp_data == 16'h0000) else $error("odd read not zero");
  a_halt_req: assert property (frame_start && halt && ready && !cold_hit && !warm_hit
    |=> st_q.tx_sh[229] && st_q.tx_sh[224]) else $error("request active during halt");
  a_pd_req: assert property (frame_start && pd_dac[0] && !halt && ready && !cold_hit && !warm_hit
    |=> !st_q.tx_sh[229]) else $error("request missing while powered down");
  a_ready_bit: assert property (frame_start && !cold_hit && !warm_hit
    |=> st_q.tx_sh[255] == $past(ready) && st_q.pos == 8'h00) else $error("ready bit wrong");
  a_slot2_zero: assert property (frame_start && !t2 && !cold_hit && !warm_hit
    |=> st_q.tx_sh[219:200] == 20'h00000 && !st_q.tx_sh[253]) else $error("invalid slot not zero");
  a_bus_ack: assert property ((avs_read || avs_write) && st_q.av_wait && !cold_hit
    |=> !st_q.av_wait ##1 st_q.av_wait) else $error("bus answer not single cycle");

  c_frame: cover property (frame_start ##1 st_q.in_frame);
  c_write: cover property (ev_write);
  c_read:  cover property (ev_read ##1 st_q.rsp_pend);
  c_cold:  cover property (cold_hit);
endmodule
`default_nettype wire

/* tb/mcl_ctl_model.sv */
// Link controller model: bit clock, sync and outgoing data
`timescale 1ns/1ps
`default_nettype none
module mcl_ctl_model (
  output logic      bclk,
  output logic      sync,
  output logic      sdo,
  output logic      rst_n,
  input  wire logic sdi
);
  // ****
  // Link driving
  // ****
  initial begin
    bclk = 1'b0;
    sync = 1'b0;
    sdo = 1'b0;
    rst_n = 1'b1;
  end
  // sync high 16 clocks, MSB first
  task automatic frame(input logic [255:0] tx, output logic [255:0] rx);
    #3;
    for (int i = 0; i <= 256; i++) begin
      bclk = 1'b1;
      sync = (i < 16);
      sdo = (i > 0) ? tx[256-i] : 1'b0;
      #40;
      bclk = 1'b0;
      if (i > 0) rx = {rx[254:0], sdi};
      #40;
    end
  endtask
  // reset low 1.5 us, clock still
  task automatic cold();
    rst_n = 1'b0;
    #1500;
    rst_n = 1'b1;
  endtask
  // sync high 1.5 us, clock still
  task automatic warm();
    sync = 1'b1;
    #1500;
    sync = 1'b0;
  endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the codec serial link
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import mcl_pkg::*;
  localparam logic [255:0] IDLE = '0;
  logic         clk, sys_rst, bclk_m, sync, sdo, rst_n, sdi;
  logic         mclk, m_prev, b_prev;
  logic [1:0]   id_pin;
  int           m_rise, b_tgl;
  logic         bclk_drive, bclk_oe, av_rd, av_wr, av_wait;
  logic [4:0]   av_addr;
  logic [31:0]  av_wd, av_q, q, f0, rng;
  logic [255:0] rx;
  logic [19:0]  sd;
  logic [15:0]  v;
  logic [6:0]   ix;
  int           err_total = 0;
  int           n_tests = 0;
  wire logic    bclk_w;
  // Wire level from the codec's enable alone: its drive when enabled, else the model's clock
  assign bclk_w = bclk_oe ? bclk_drive : bclk_m;
  mcl_codec_link #(.REG_WORDS(64)) DUT (
    .clk(clk), .sys_rst(sys_rst), .mclk(mclk), .bclk_sense(bclk_w),
    .bclk_drive(bclk_drive), .bclk_oe(bclk_oe), .link_sync(sync),
    .link_sdo(sdo), .link_sdi(sdi), .link_rst_n(rst_n), .id_strap(id_pin),
    .avs_address(av_addr), .avs_read(av_rd), .avs_write(av_wr),
    .avs_writedata(av_wd), .avs_readdata(av_q), .avs_waitrequest(av_wait)
  );
  mcl_ctl_model u_ctl (.bclk(bclk_m), .sync(sync), .sdo(sdo), .rst_n(rst_n), .sdi(sdi));
  // ****
  // Helpers
  // ****
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [255:0] mk(input logic [15:0] s0, input logic [19:0] s1, s2, s5);
    return {s0, s1, s2, 40'h0, s5, 140'h0};
  endfunction
  // write: slots 1 and 2 tagged
  function automatic logic [255:0] wr(input logic [6:0] i, input logic [15:0] d);
    return mk(16'hE000, {1'b0, i, 12'h000}, {d, 4'h0}, 20'h0);
  endfunction
  // read: slot 2 untagged and zero
  function automatic logic [255:0] rd(input logic [6:0] i);
    return mk(16'hC000, {1'b1, i, 12'h000}, 20'h0, 20'h0);
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s exp=%h seen=%h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Bus cycle held until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] wd,
                     output logic [31:0] rq);
    int n;
    n = 0;
    @(posedge clk);
    av_addr <= a;
    av_wd <= wd;
    av_wr <= w;
    av_rd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (av_wait !== 1'b0 && n < 64);
    rq = av_q;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
    if (n >= 64) begin
      err_total++;
      tally_and_finish();
    end
  endtask
  // One frame, then slot 0, requests and idle slot 2
  task automatic fr(input logic [255:0] tx, input logic ans, t5, r1n, r2n);
    u_ctl.frame(tx, rx);
    check("slot0", 32'(rx[255:240]), {16'h0, 2'b11, ans, 2'b0, t5, 10'h0});
    check("slot1", 32'({rx[239], rx[231:220]}), 32'({3'b0, r1n, 4'h0, r2n, 4'h0}));
    if (!ans) check("slot2", 32'(rx[219:200]), 32'h0);
  endtask
  task automatic ans_chk(input logic [6:0] i, input logic [15:0] d);
    check("echo", 32'(rx[238:232]), 32'(i));
    check("rdata", 32'(rx[219:200]), {12'h0, d, 4'h0});
  endtask
  // ****
  // Clock, watchdog, sequence
  // ****
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Master clock, 40 ns period, gives an 80 ns bit clock when primary
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    #900000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    sys_rst = 1'b1;
    av_rd = 1'b0;
    av_wr = 1'b0;
    av_addr = 5'h00;
    av_wd = 32'h0;
    rng = 32'h51CD;
    id_pin = 2'b10;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (10) @(posedge clk);
    check("oe", 32'(bclk_oe), 32'h0);
    u_ctl.frame(IDLE, rx);
    check("rdy0", 32'(rx[255]), 32'h0);
    fr(IDLE, 0, 0, 0, 0);
    fr(wr(REG_PWR_IDX, 16'h0800), 0, 0, 0, 0);
    fr(rd(REG_PWR_IDX), 0, 0, 0, 0);
    fr(IDLE, 1, 0, 0, 0);
    ans_chk(REG_PWR_IDX, 16'h0800);
    fr(wr(REG_LINK_IDX, 16'h1000), 0, 0, 0, 0);
    fr(IDLE, 0, 0, 1, 1);
    fr(wr(REG_LINK_IDX, 16'h0000), 0, 0, 1, 1);
    rng = xs(rng);
    sd = {rng[15:0], 4'h0};
    fr(wr(REG_RESET_IDX, 16'h0000), 0, 0, 0, 0);
    // requested slot 5 supplied, line powered again
    fr(mk(16'h8400, 20'h0, 20'h0, sd), 0, 0, 0, 0);
    fr(IDLE, 0, 0, 1, 0);
    bus(1'b0, AV_STATUS, 32'h0, q);
    check("status", q & 32'hFFFF_FFFD, 32'h5);
    bus(1'b0, AV_DAC1, 32'h0, q);
    check("dac1", q, {16'h0, sd[19:4]});
    bus(1'b0, AV_FRAMES, 32'h0, f0);
    fr(IDLE, 0, 0, 0, 0);
    bus(1'b0, AV_FRAMES, 32'h0, q);
    check("frames", q, f0 + 32'h1);
    bus(1'b1, 5'h18, 32'hFFFF, q);
    bus(1'b0, 5'h18, 32'h0, q);
    check("unmapped", q, 32'h0);
    rng = xs(rng);
    bus(1'b1, AV_ADC1, rng, q);
    fr(IDLE, 0, 1, 0, 0);
    check("adc1", 32'(rx[159:140]), {12'h0, rng[15:0], 4'h0});
    fr(wr(7'h43, 16'hFFFF), 0, 0, 0, 0);
    fr(rd(7'h43), 0, 0, 0, 0);
    fr(IDLE, 1, 0, 0, 0);
    ans_chk(7'h43, 16'h0);
    for (int k = 0; k < 2; k++) begin
      rng = xs(rng);
      ix = {rng[22:17], 1'b0};
      if (ix == REG_RESET_IDX || ix == REG_PWR_IDX || ix == REG_LINK_IDX) ix = 7'h02;
      v = rng[15:0];
      fr(wr(ix, v), 0, 0, 0, 0);
      fr(rd(ix), 0, 0, 0, 0);
      fr(IDLE, 1, 0, 0, 0);
      ans_chk(ix, v);
    end
    u_ctl.warm();
    u_ctl.frame(IDLE, rx);
    fr(rd(ix), 0, 0, 0, 0);
    fr(IDLE, 1, 0, 0, 0);
    ans_chk(ix, v);
    u_ctl.cold();
    u_ctl.frame(IDLE, rx);
    check("rdy_cold", 32'(rx[255]), 32'h0);
    fr(rd(ix), 0, 0, 0, 0);
    fr(IDLE, 1, 0, 0, 0);
    ans_chk(ix, 16'h0);
    // primary strap after a second reset: bit clock is master clock halved
    @(posedge clk);
    id_pin <= 2'b11;
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (20) @(posedge clk);
    check("oe_pri", 32'(bclk_oe), 32'h1);
    m_rise = 0;
    b_tgl = 0;
    m_prev = mclk;
    b_prev = bclk_drive;
    for (int c = 0; c < 80; c++) begin
      @(posedge clk);
      if (mclk && !m_prev) m_rise++;
      if (bclk_drive !== b_prev) b_tgl++;
      m_prev = mclk;
      b_prev = bclk_drive;
    end
    check("mclk_rises", 32'(m_rise), 32'h14);
    check("bclk_toggles", 32'(b_tgl), 32'(m_rise));
    tally_and_finish();
  end
endmodule
`default_nettype wire
